/* common/vrc_consts.svh */
// Constants for the voltage reference control block
`ifndef VRC_CONSTS_SVH
`define VRC_CONSTS_SVH
`define VRC_ADDR_CTRL       4'h0
`define VRC_ADDR_IRQ_STATUS 4'h1
`define VRC_ADDR_IRQ_MASK   4'h2
`define VRC_ADDR_GAIN_STAT  4'h3
`define VRC_BIT_ENABLE      7
`define VRC_BIT_READY       6
`define VRC_BIT_TEMP_EN     5
`define VRC_BIT_TEMP_RANGE  4
`define VRC_CMP_GAIN_HI     3
`define VRC_CMP_GAIN_LO     2
`define VRC_ADC_GAIN_HI     1
`define VRC_ADC_GAIN_LO     0
`define VRC_CTRL_RESET      8'h00
`define VRC_CTRL_WMASK      8'hBF
`define VRC_IRQ_WIDTH       2
`define VRC_IRQ_READY_RISE  0
`define VRC_IRQ_READY_FALL  1
`define VRC_SETTLE_NS       25000
`define VRC_CLK_PERIOD_NS   40
`define VRC_GAIN_OFF        2'h0
`define VRC_GAIN_X1         2'h1
`define VRC_GAIN_X2         2'h2
`define VRC_GAIN_X4         2'h3
`endif

/* common/vrc_pkg.sv */
// Types shared by the voltage reference control block
package vrc_pkg;
   typedef enum logic [1:0] {
      VRC_BUF_OFF = 2'h0,
      VRC_BUF_X1  = 2'h1,
      VRC_BUF_X2  = 2'h2,
      VRC_BUF_X4  = 2'h3
   } vrc_gain_t;

   typedef struct packed {
      logic      reference_enable;
      logic      temp_indicator_enable;
      logic      temp_indicator_range;
      vrc_gain_t comparator_path_gain;
      vrc_gain_t converter_path_gain;
   } vrc_ctrl_t;

   typedef struct packed {
      logic off;
      logic x1;
      logic x2;
      logic x4;
   } vrc_buf_sel_t;
endpackage

/* hdl/vrc_gain_dec.sv */
// Gain field decoder for one reference buffer path
`timescale 1ns/1ps
`include "vrc_consts.svh"
module vrc_gain_dec (
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire logic           ref_on,
   input  vrc_pkg::vrc_gain_t  gain,
   output vrc_pkg::vrc_buf_sel_t sel
);
   import vrc_pkg::*;
   // 11=4x, 10=2x, 01=1x, 00=off; reference off forces the buffer off
   wire on  = ref_on && (gain != VRC_BUF_OFF);
   wire x1  = on && (gain == VRC_BUF_X1);
   wire x2  = on && (gain == VRC_BUF_X2);
   wire x4  = on && (gain == VRC_BUF_X4);

   // Registered so the analog switches never see decode glitches
   always_ff @(posedge clk) begin
      if (rst) begin
         sel <= '{off: 1'b1, x1: 1'b0, x2: 1'b0, x4: 1'b0};
      end else begin
         sel <= '{off: !on, x1: x1, x2: x2, x4: x4};
      end
   end
endmodule

/* hdl/vrc_settle.sv */
// Stabilization counter that delays the ready flag after enable
`timescale 1ns/1ps
`include "vrc_consts.svh"
module vrc_settle #(
   parameter int SETTLE_CYCLES = 625
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic enable,
   output logic      ready
);
   localparam int CW = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES);
   logic [CW-1:0] count_q;
   wire           done = (count_q == LAST);

   // Count while enabled, cleared whenever enable is low
   always_ff @(posedge clk) begin
      if (rst || !enable) begin
         count_q <= '0;
      end else if (!done) begin
         count_q <= count_q + CW'(1);
      end
   end

   // Ready only after the full interval and only while enabled
   always_ff @(posedge clk) begin
      if (rst) begin
         ready <= 1'b0;
      end else begin
         ready <= enable && done;
      end
   end
endmodule

/* hdl/vrc_top.sv */
// Voltage reference control register bank with ready tracking and interrupt
//
// Functional notes
// - Enable bit 7 turns reference on
// - Bit 6 reads ready, zero otherwise
// - Ready held low during stabilization interval
// - Bit 5 enables temperature indicator
// - Bit 4 selects four or two drops
// - Two independent gain buffers, 1x/2x/4x
// - Bits 3:2 comparator path gain decode
// - Bits 1:0 converter path gain decode
//
// Register map (four byte-wide indices)
//   Index 0: control byte
//     bit 7     reference enable, read/write
//     bit 6     reference ready, read-only, writes ignored
//     bit 5     temperature indicator enable
//     bit 4     temperature indicator range, one for high range
//     bits 3:2  comparator and DAC path buffer gain
//     bits 1:0  converter path buffer gain
//   Index 1: interrupt status, write one to clear
//     bit 0     ready rose
//     bit 1     ready fell
//   Index 2: interrupt mask, same layout as the status
//   Index 3: gain status, read-only
//     bits 7:4  comparator path select, x4 x2 x1 off
//     bits 3:0  converter path select, x4 x2 x1 off
//   Other indices read as zero and ignore writes
//
// Gain field coding, both paths alike
//   11 four times, 10 two times, 01 unity, 00 buffer off
//   A disabled reference forces both buffers to off
//
// Timing
//   Writes land at the edge that samples the strobe
//   Read data stand in the cycle after the read strobe only
//   Enable and temperature indicator outputs trail the control byte by one cycle
//   Buffer selects trail by two cycles, decoder plus output stage
//   Ready rises a settle interval plus one cycle after the enable lands
//   Ready drops one cycle after the enable is cleared
//
// Interrupts
//   A new event wins over a clear in the same cycle
//   The interrupt line follows next-state status, one cycle late
//
// Limitations
//   The settle interval is a count of clock cycles only; it does
//   not track supply or temperature, so pick SETTLE_NS with margin
//   The ready flag says nothing about the reference level itself
//   Buffer output levels are not checked against the supply here
`timescale 1ns/1ps
`include "vrc_consts.svh"
module vrc_top #(
   parameter int SETTLE_NS = `VRC_SETTLE_NS
) (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic [3:0]      reg_addr,
   input  wire logic [7:0]      reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic [7:0]           reg_rdata,
   output logic                 irq,
   output logic                 reference_on,
   output logic                 reference_ready,
   output logic                 temp_indicator_on,
   output logic                 temp_indicator_high_range,
   output vrc_pkg::vrc_buf_sel_t comparator_buf,
   output vrc_pkg::vrc_buf_sel_t converter_buf
);
   import vrc_pkg::*;

   // Least time rounds up to whole cycles, never below one
   localparam int SETTLE_RAW =
      (SETTLE_NS + `VRC_CLK_PERIOD_NS - 1) / `VRC_CLK_PERIOD_NS;
   localparam int SETTLE_CYCLES = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;

   // Stored control fields; the ready position has no storage
   vrc_ctrl_t                  ctrl_q;
   // Interrupt status and mask, one bit per ready event
   logic [`VRC_IRQ_WIDTH-1:0]  irq_stat_q;
   logic [`VRC_IRQ_WIDTH-1:0]  irq_mask_q;
   // Ready level one cycle back, for edge detection
   logic                       ready_prev_q;
   // Ready flag straight from the settle counter
   logic                       ready_w;
   // Registered buffer selects from the two decoders
   vrc_buf_sel_t               cmp_sel_w;
   vrc_buf_sel_t               adc_sel_w;

   // Address decode
   wire sel_ctrl = (reg_addr == `VRC_ADDR_CTRL);
   wire sel_stat = (reg_addr == `VRC_ADDR_IRQ_STATUS);
   wire sel_mask = (reg_addr == `VRC_ADDR_IRQ_MASK);
   wire sel_gain = (reg_addr == `VRC_ADDR_GAIN_STAT);

   // Write strobes per register; the gain status index takes no writes
   wire wr_ctrl  = reg_wr && sel_ctrl;
   wire wr_stat  = reg_wr && sel_stat;
   wire wr_mask  = reg_wr && sel_mask;

   // Ready flag events for the interrupt logic
   wire ready_rise = ready_w && !ready_prev_q;
   wire ready_fall = !ready_w && ready_prev_q;
   wire [`VRC_IRQ_WIDTH-1:0] irq_evt = {ready_fall, ready_rise};

   // Write-one-to-clear mask for the status bits
   wire [`VRC_IRQ_WIDTH-1:0] irq_clr =
      wr_stat ? reg_wdata[`VRC_IRQ_WIDTH-1:0] : '0;

   // Control byte as software sees it; ready bit is read-only
   wire [7:0] ctrl_view = {ctrl_q.reference_enable, ready_w,
                           ctrl_q.temp_indicator_enable, ctrl_q.temp_indicator_range,
                           ctrl_q.comparator_path_gain, ctrl_q.converter_path_gain};
   // Gain status byte: one-hot selects of both buffers, off in the low bit
   wire [7:0] gain_view = {cmp_sel_w.x4, cmp_sel_w.x2, cmp_sel_w.x1, cmp_sel_w.off,
                           adc_sel_w.x4, adc_sel_w.x2, adc_sel_w.x1, adc_sel_w.off};
   // Status and mask widened to a byte, upper bits read as zero
   wire [7:0] stat_view = {{(8-`VRC_IRQ_WIDTH){1'b0}}, irq_stat_q};
   wire [7:0] mask_view = {{(8-`VRC_IRQ_WIDTH){1'b0}}, irq_mask_q};

   // Read selection; unmapped indices read as zero
   wire [7:0] rd_mux =
      sel_ctrl ? ctrl_view :
      sel_stat ? stat_view :
      sel_mask ? mask_view :
      sel_gain ? gain_view : 8'h00;

   // Write data split into named fields; bit 6 is never stored
   wire       wd_enable   = reg_wdata[`VRC_BIT_ENABLE];
   wire       wd_temp_en  = reg_wdata[`VRC_BIT_TEMP_EN];
   wire       wd_temp_rng = reg_wdata[`VRC_BIT_TEMP_RANGE];
   wire [1:0] wd_cmp_gain = reg_wdata[`VRC_CMP_GAIN_HI:`VRC_CMP_GAIN_LO];
   wire [1:0] wd_adc_gain = reg_wdata[`VRC_ADC_GAIN_HI:`VRC_ADC_GAIN_LO];

   // Reset image of the control byte, picked apart per field
   wire [7:0] ctrl_rst = `VRC_CTRL_RESET;

   // Reference enable; the settle counter restarts from its rise
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q.reference_enable <= ctrl_rst[`VRC_BIT_ENABLE];
      end else if (wr_ctrl) begin
         ctrl_q.reference_enable <= wd_enable;
      end
   end

   // Temperature indicator enable
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q.temp_indicator_enable <= ctrl_rst[`VRC_BIT_TEMP_EN];
      end else if (wr_ctrl) begin
         ctrl_q.temp_indicator_enable <= wd_temp_en;
      end
   end

   // Temperature indicator range, one for four junction drops
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q.temp_indicator_range <= ctrl_rst[`VRC_BIT_TEMP_RANGE];
      end else if (wr_ctrl) begin
         ctrl_q.temp_indicator_range <= wd_temp_rng;
      end
   end

   // Comparator and DAC path gain field
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q.comparator_path_gain <= vrc_gain_t'(ctrl_rst[`VRC_CMP_GAIN_HI:`VRC_CMP_GAIN_LO]);
      end else if (wr_ctrl) begin
         ctrl_q.comparator_path_gain <= vrc_gain_t'(wd_cmp_gain);
      end
   end

   // Converter path gain field
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q.converter_path_gain <= vrc_gain_t'(ctrl_rst[`VRC_ADC_GAIN_HI:`VRC_ADC_GAIN_LO]);
      end else if (wr_ctrl) begin
         ctrl_q.converter_path_gain <= vrc_gain_t'(wd_adc_gain);
      end
   end

   // Stabilization interval before ready
   vrc_settle #(
      .SETTLE_CYCLES (SETTLE_CYCLES)
   ) u_settle (
      .clk    (clk),
      .rst    (rst),
      .enable (ctrl_q.reference_enable),
      .ready  (ready_w)
   );

   // Two independent buffers, each with its own field
   vrc_gain_dec u_cmp_dec (                  // Comparator and DAC path
      .clk    (clk),
      .rst    (rst),
      .ref_on (ctrl_q.reference_enable),
      .gain   (ctrl_q.comparator_path_gain),
      .sel    (cmp_sel_w)
   );
   vrc_gain_dec u_adc_dec (                  // Converter path
      .clk    (clk),
      .rst    (rst),
      .ref_on (ctrl_q.reference_enable),
      .gain   (ctrl_q.converter_path_gain),
      .sel    (adc_sel_w)
   );

   // Previous ready level, for the rise and fall events
   // Reset low like the ready flag, so no false edge follows reset
   always_ff @(posedge clk) begin
      if (rst) begin
         ready_prev_q <= 1'b0;
      end else begin
         ready_prev_q <= ready_w;
      end
   end

   // Status next value: a new event wins over a same-cycle clear
   wire [`VRC_IRQ_WIDTH-1:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;
   wire [`VRC_IRQ_WIDTH-1:0] irq_mask_d =
      wr_mask ? reg_wdata[`VRC_IRQ_WIDTH-1:0] : irq_mask_q;

   // One sticky status bit and one mask bit per event
   genvar ev;
   generate
      for (ev = 0; ev < `VRC_IRQ_WIDTH; ev = ev + 1) begin : g_irq_bit
         // Status bit holds until software writes a one to it
         always_ff @(posedge clk) begin
            if (rst) begin
               irq_stat_q[ev] <= 1'b0;
            end else begin
               irq_stat_q[ev] <= irq_stat_d[ev];
            end
         end

         // Mask bit, same layout as the status bit
         always_ff @(posedge clk) begin
            if (rst) begin
               irq_mask_q[ev] <= 1'b0;
            end else begin
               irq_mask_q[ev] <= irq_mask_d[ev];
            end
         end
      end
   endgenerate

   // Read data stand only in the cycle after the strobe
   // Zero otherwise, so a stale value is never mistaken for an answer
   wire [7:0] rdata_d = reg_rd ? rd_mux : 8'h00;

   // Read data register
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= rdata_d;
      end
   end

   // Interrupt from next-state status, so it lines up with the status bit
   wire irq_d = |(irq_stat_d & irq_mask_q);

   // Interrupt level, high while an unmasked status bit is set
   // Registered so the line never glitches on a write
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_d;
      end
   end

   // Reference on, one cycle behind the control byte
   // Kept apart from the decoders so it can lead the buffers
   always_ff @(posedge clk) begin
      if (rst) begin
         reference_on <= 1'b0;
      end else begin
         reference_on <= ctrl_q.reference_enable;
      end
   end

   // Ready flag as seen outside, one cycle behind the counter
   // The register view reads the counter side, one cycle earlier
   always_ff @(posedge clk) begin
      if (rst) begin
         reference_ready <= 1'b0;
      end else begin
         reference_ready <= ready_w;
      end
   end

   // Temperature indicator enable
   // No interlock with the reference; software orders the two
   always_ff @(posedge clk) begin
      if (rst) begin
         temp_indicator_on <= 1'b0;
      end else begin
         temp_indicator_on <= ctrl_q.temp_indicator_enable;
      end
   end

   // Temperature indicator range, high for four drops
   // High range needs more supply headroom than low range
   always_ff @(posedge clk) begin
      if (rst) begin
         temp_indicator_high_range <= 1'b0;
      end else begin
         temp_indicator_high_range <= ctrl_q.temp_indicator_range;
      end
   end

   // Comparator path buffer select, resets to off
   // One-hot, so the analog side never sees two gains at once
   always_ff @(posedge clk) begin
      if (rst) begin
         comparator_buf <= '{off: 1'b1, x1: 1'b0, x2: 1'b0, x4: 1'b0};
      end else begin
         comparator_buf <= cmp_sel_w;
      end
   end

   // Converter path buffer select, resets to off
   // Independent of the comparator path select
   always_ff @(posedge clk) begin
      if (rst) begin
         converter_buf <= '{off: 1'b1, x1: 1'b0, x2: 1'b0, x4: 1'b0};
      end else begin
         converter_buf <= adc_sel_w;
      end
   end
endmodule

/* test/vrc_top_asserts.sv */
// Concurrent checks on the ports of the voltage reference control block
`timescale 1ns/1ps
module vrc_top_asserts #(
   parameter int SETTLE_NS = 400
) (
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic [3:0]            reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  irq,
   input wire logic                  reference_on,
   input wire logic                  reference_ready,
   input wire logic                  temp_indicator_on,
   input wire logic                  temp_indicator_high_range,
   input wire vrc_pkg::vrc_buf_sel_t comparator_buf,
   input wire vrc_pkg::vrc_buf_sel_t converter_buf
);
   import vrc_pkg::*;
   localparam int RDY_LO = SETTLE_NS / 40 - 2;
   localparam int RDY_HI = SETTLE_NS / 40 + 6;
   logic [7:0] last_q;
   logic       wr_q;
   wire        ctrl_wr = reg_wr && reg_addr == 4'h0;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Last control write, so outputs can be tied to what software wrote
   always_ff @(posedge clk) begin
      wr_q <= !rst && ctrl_wr;
      if (ctrl_wr) last_q <= reg_wdata;
   end
   // A control write with no second one right behind it
   sequence settled_s;
      wr_q && !ctrl_wr;
   endsequence
   en_follow_a: assert property (settled_s |=> reference_on == last_q[7])
      else $error("reference enable output does not follow control write");
   temp_en_a: assert property (settled_s |=> temp_indicator_on == last_q[5])
      else $error("temperature enable does not follow control write");
   temp_rng_a: assert property (settled_s |=> temp_indicator_high_range == last_q[4])
      else $error("temperature range does not follow control write");
   cmp_gain_a: assert property (settled_s |=> ##[0:1]
      comparator_buf == (last_q[7] ? 4'h8 >> last_q[3:2] : 4'h8))
      else $error("comparator buffer select wrong");
   cnv_gain_a: assert property (settled_s |=> ##[0:1]
      converter_buf == (last_q[7] ? 4'h8 >> last_q[1:0] : 4'h8))
      else $error("converter buffer select wrong");
   rdy_on_a: assert property ($rose(reference_ready) |-> reference_on)
      else $error("ready rose while reference disabled");
   rdy_drop_a: assert property ($fell(reference_on) |-> ##[0:2] !reference_ready)
      else $error("ready stayed high after disable");
   rdy_hold_a: assert property ($rose(reference_on) |-> !reference_ready [*8])
      else $error("ready set before stabilization");
   rdy_due_a: assert property ($rose(reference_on) |->
      ##[RDY_LO:RDY_HI] (reference_ready || !reference_on))
      else $error("ready late after enable");
   rdy_read_a: assert property (reg_rd && reg_addr == 4'h0 |=>
      reg_rdata[6] == reference_ready)
      else $error("ready bit read differs from ready output");
endmodule

bind vrc_top vrc_top_asserts #(.SETTLE_NS(SETTLE_NS)) i_asserts (.clk(clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .irq(irq), .reference_on(reference_on),
   .reference_ready(reference_ready), .temp_indicator_on(temp_indicator_on),
   .temp_indicator_high_range(temp_indicator_high_range),
   .comparator_buf(comparator_buf), .converter_buf(converter_buf));

/* test/vrc_top_tb_top.sv */
// Self-checking bench for the voltage reference control block
`timescale 1ns/1ps
module vrc_top_tb_top;
   import vrc_pkg::*;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic [3:0]   reg_addr = 4'h0;
   logic [7:0]   reg_wdata = 8'h00;
   logic         reg_wr = 1'b0;
   logic         reg_rd = 1'b0;
   logic [7:0]   reg_rdata;
   logic         irq;
   logic         ref_on;
   logic         ref_rdy;
   logic         t_on;
   logic         t_hi;
   vrc_buf_sel_t cmp_buf;
   vrc_buf_sel_t cnv_buf;
   logic [1:0]   g = 2'h0;
   int           mismatches = 0;
   int           check_count = 0;
   int           cycles = 0;
   // Short settle of 10 cycles keeps the run brief
   vrc_top #(.SETTLE_NS(400)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .reference_on(ref_on), .reference_ready(ref_rdy),
      .temp_indicator_on(t_on), .temp_indicator_high_range(t_hi),
      .comparator_buf(cmp_buf), .converter_buf(cnv_buf));
   // 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so look there
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Hang guard, far above the 90 or so cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         mismatches++;
         finish_test();
      end
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(4'h0, 8'h00);
      chk({cmp_buf, cnv_buf}, 8'h88);
      wr(4'h0, 8'h7F);
      rd(4'h0, 8'h3F);
      chk({ref_on, t_on, t_hi}, 8'h03);
      chk({cmp_buf, cnv_buf}, 8'h88);
      wr(4'h0, 8'h80);
      rd(4'h0, 8'h80);
      repeat (4) begin
         wr(4'h0, {2'b10, g[0], g[1], g, ~g});
         idle(3);
         chk({t_on, t_hi}, {6'h00, g[0], g[1]});
         chk({cmp_buf, cnv_buf}, {4'h8 >> g, 4'h8 >> ~g});
         g++;
      end
      idle(12);
      rd(4'h0, 8'hFC);
      rd(4'h1, 8'h01);
      chk({7'h00, irq}, 8'h00);
      wr(4'h2, 8'h03);
      idle(2);
      chk({7'h00, irq}, 8'h01);
      wr(4'h1, 8'h01);
      idle(2);
      chk({7'h00, irq}, 8'h00);
      wr(4'h0, 8'h00);
      idle(3);
      chk({ref_on, ref_rdy}, 8'h00);
      rd(4'h1, 8'h02);
      chk({7'h00, irq}, 8'h01);
      // Enable, drop and re-enable: the settle count has to start over
      wr(4'h0, 8'h80);
      idle(5);
      wr(4'h0, 8'h00);
      wr(4'h0, 8'h80);
      idle(5);
      rd(4'h0, 8'h80);
      wr(4'h3, 8'hFF);
      rd(4'h3, 8'h11);
      rd(4'h9, 8'h00);
      finish_test();
   end
endmodule
